// [shared/svc_defs.vh]
// Purpose: constants for the synthesizer calibration sequencer
// Assumes: 25 MHz system clock, byte-wide register port
// Notes:   offsets are 10-bit register addresses
`ifndef SVC_DEFS_VH
`define SVC_DEFS_VH

// sized to the 16-bit timer so cycle products need no truncation
`define SVC_CLK_MHZ          16'h0019
`define SVC_CAL_US           16'h008E
`define SVC_CAL_CYC          (`SVC_CAL_US * `SVC_CLK_MHZ)
`define SVC_SETTLE_US        16'h0038
`define SVC_SETTLE_CYC       (`SVC_SETTLE_US * `SVC_CLK_MHZ)
`define SVC_STEP_US          16'h0002
`define SVC_STEP_CYC         (`SVC_STEP_US * `SVC_CLK_MHZ)

`define SVC_OFF_MOD_CFG      10'h115
`define SVC_OFF_MODE_CTL     10'h11A
`define SVC_OFF_RX_SETTLE    10'h13E
`define SVC_OFF_TX_SETTLE    10'h13F
`define SVC_OFF_CAL_CTL      10'h338
`define SVC_OFF_CAL_DONE     10'h339
`define SVC_OFF_OVR_EN       10'h3CD
`define SVC_OFF_CAL_CFG      10'h3D0
`define SVC_OFF_BAND_OVR     10'h3CB
`define SVC_OFF_AMPL_OVR     10'h3CC
`define SVC_OFF_BAND_RES     10'h3DA
`define SVC_OFF_AMPL_RES     10'h3DB

// field positions
`define SVC_MOD_GAUSS_BIT    4
`define SVC_MOD_OOK_BIT      2
`define SVC_MODE_CUSTOM_BIT  3
`define SVC_CALCTL_EN_BIT    0
`define SVC_DONE_VCO_BIT     0
`define SVC_DONE_LOCK_BIT    1

`define SVC_OVR_BYPASS       8'h03
`define SVC_CFG_BYPASS       8'h0F
`define SVC_RST_BYTE         8'h00
`define SVC_RST_CALCTL       8'h01

// loop bandwidth codes
`define SVC_BW_92            3'h0
`define SVC_BW_130           3'h1
`define SVC_BW_174           3'h2
`define SVC_BW_226           3'h3
`define SVC_BW_305           3'h4
`define SVC_BW_382           3'h5
`define SVC_BW_185           3'h6

// data rate band edges in units of 100 bps
`define SVC_RATE_496         12'd496
`define SVC_RATE_1296        12'd1296
`define SVC_RATE_1792        12'd1792
`define SVC_RATE_2400        12'd2400

`endif

// [logic/svc_delay_timer.v]
// Purpose: loadable down counter marking the end of a timed interval
// Assumes: load and count come from the same clock domain
// Notes:   done pulses one cycle early so a consumer reacting on it moves exactly i_cycles after load
//          loads below two behave as two
`timescale 1ns/1ps
module svc_delay_timer (
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire        i_load,
  input  wire [15:0] i_cycles,
  output reg         o_done
);
  reg [15:0] cnt_r;
  reg        run_r;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r  <= 16'h0000;
      run_r  <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_load) begin
        cnt_r <= i_cycles;
        run_r <= 1'b1;
      end else if (run_r) begin
        // the state machine takes one more edge to act on done
        if (cnt_r <= 16'h0002) begin
          run_r  <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end
endmodule // svc_delay_timer

// [logic/svc_synth_seq.v]
// Function
// RULE_01: state command starts VCO self-calibration
// RULE_02: calibration lasts fixed 142 microseconds
// RULE_03: completion flag readable at 0x339
// RULE_04: default settling delay is 56 microseconds
// RULE_05: custom enable bit selects programmed delays
// RULE_06: receive delay 0x13E, transmit delay 0x13F
// RULE_07: delay 2 to 512 us, 2 us steps
// RULE_08: transmit bandwidth from modulation and rate
// RULE_09: receive always uses 92 kHz bandwidth
// RULE_10: output divider 2 or 4 matches VCO
// RULE_11: gaussian shaping only when enabled, BT 0.5
// RULE_12: host stores band and amplitude results
// RULE_13: host override setup bypasses calibration
// RULE_14: state reported only after all delays
//
// Purpose: synthesizer calibration and settling sequencer
// Assumes: byte register port on the same clock; rate and vco band come from core logic
// Notes:   calibration engine itself is analog; its results arrive on i_cal_band / i_cal_ampl
`timescale 1ns/1ps
`include "svc_defs.vh"
module svc_synth_seq (
  input  wire        i_clk,
  input  wire        i_arst_n,
  input  wire        i_go_receive_cmd,
  input  wire        i_go_transmit_cmd,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [9:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire [11:0] i_data_rate,
  input  wire        i_vco_quad,
  input  wire [7:0]  i_cal_band,
  input  wire [7:0]  i_cal_ampl,
  input  wire        i_tx_bit,
  output reg  [7:0]  o_reg_rdata,
  output reg         o_cal_run,
  output reg  [7:0]  o_vco_band,
  output reg  [7:0]  o_vco_ampl,
  output reg  [2:0]  o_loop_bw,
  output reg         o_div4,
  output reg         o_gauss_en,
  output reg         o_tx_bit,
  output reg         o_receive_state,
  output reg         o_transmit_state
);
  localparam ST_IDLE   = 2'd0;
  localparam ST_CAL    = 2'd1;
  localparam ST_SETTLE = 2'd2;
  localparam ST_ON     = 2'd3;

  reg [1:0]  state_r;
  reg [1:0]  state_nxt;
  reg        dir_tx_r;
  reg [7:0]  mod_cfg_r;
  reg [7:0]  mode_ctl_r;
  reg [7:0]  rx_settle_r;
  reg [7:0]  tx_settle_r;
  reg [7:0]  cal_ctl_r;
  reg [7:0]  ovr_en_r;
  reg [7:0]  cal_cfg_r;
  reg [7:0]  band_ovr_r;
  reg [7:0]  ampl_ovr_r;
  reg [7:0]  band_res_r;
  reg [7:0]  ampl_res_r;
  reg        vco_done_r;
  reg        tmr_load;
  reg [15:0] tmr_cycles;
  wire       tmr_done;
  wire       cmd;
  wire       bypass;
  wire [7:0] settle_code;
  wire [15:0] custom_cyc;

  assign cmd = i_go_receive_cmd | i_go_transmit_cmd;
  // bypass needs the full override setup, not just one field
  assign bypass = (ovr_en_r == `SVC_OVR_BYPASS) && (cal_cfg_r == `SVC_CFG_BYPASS); // RULE_13
  assign settle_code = i_go_transmit_cmd ? tx_settle_r : rx_settle_r; // RULE_06
  // code n means (n+1) steps: 0 gives 2 us, 255 gives 512 us
  assign custom_cyc = ({8'h00, settle_code} + 16'h0001) * `SVC_STEP_CYC; // RULE_07

  svc_delay_timer u_tmr (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_load   (tmr_load),
    .i_cycles (tmr_cycles),
    .o_done   (tmr_done)
  );

  always @* begin
    state_nxt  = state_r;
    tmr_load   = 1'b0;
    tmr_cycles = 16'h0000;
    case (state_r)
      ST_ON, ST_IDLE: begin
        if (cmd) begin
          tmr_load = 1'b1;
          if (bypass || !cal_ctl_r[`SVC_CALCTL_EN_BIT]) begin
            state_nxt = ST_SETTLE;
            if (mode_ctl_r[`SVC_MODE_CUSTOM_BIT]) begin // RULE_05
              tmr_cycles = custom_cyc;
            end else begin
              tmr_cycles = `SVC_SETTLE_CYC; // RULE_04
            end
          end else begin
            state_nxt  = ST_CAL; // RULE_01
            tmr_cycles = `SVC_CAL_CYC; // RULE_02
          end
        end
      end
      ST_CAL: begin
        if (tmr_done) begin
          state_nxt = ST_SETTLE;
          tmr_load  = 1'b1;
          if (mode_ctl_r[`SVC_MODE_CUSTOM_BIT]) begin // RULE_05
            tmr_cycles = ({8'h00, (dir_tx_r ? tx_settle_r : rx_settle_r)} + 16'h0001) * `SVC_STEP_CYC; // RULE_06
          end else begin
            tmr_cycles = `SVC_SETTLE_CYC; // RULE_04
          end
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          state_nxt = ST_ON; // RULE_14
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r     <= ST_IDLE;
      dir_tx_r    <= 1'b0;
      mod_cfg_r   <= `SVC_RST_BYTE;
      mode_ctl_r  <= `SVC_RST_BYTE;
      rx_settle_r <= `SVC_RST_BYTE;
      tx_settle_r <= `SVC_RST_BYTE;
      cal_ctl_r   <= `SVC_RST_CALCTL;
      ovr_en_r    <= `SVC_RST_BYTE;
      cal_cfg_r   <= `SVC_RST_BYTE;
      band_ovr_r  <= `SVC_RST_BYTE;
      ampl_ovr_r  <= `SVC_RST_BYTE;
      band_res_r  <= `SVC_RST_BYTE;
      ampl_res_r  <= `SVC_RST_BYTE;
      vco_done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cmd && (state_r == ST_IDLE || state_r == ST_ON)) begin
        dir_tx_r <= i_go_transmit_cmd;
      end
      // hardware events win over the start that clears the flag
      if (state_r == ST_CAL && tmr_done) begin
        vco_done_r <= 1'b1; // RULE_03
        band_res_r <= i_cal_band; // RULE_12
        ampl_res_r <= i_cal_ampl; // RULE_12
      end else if (state_nxt == ST_CAL && state_r != ST_CAL) begin
        vco_done_r <= 1'b0;
      end
      if (i_reg_wr) begin
        case (i_reg_addr)
          `SVC_OFF_MOD_CFG:   mod_cfg_r   <= i_reg_wdata;
          `SVC_OFF_MODE_CTL:  mode_ctl_r  <= i_reg_wdata;
          `SVC_OFF_RX_SETTLE: rx_settle_r <= i_reg_wdata;
          `SVC_OFF_TX_SETTLE: tx_settle_r <= i_reg_wdata;
          `SVC_OFF_CAL_CTL:   cal_ctl_r   <= i_reg_wdata;
          `SVC_OFF_OVR_EN:    ovr_en_r    <= i_reg_wdata;
          `SVC_OFF_CAL_CFG:   cal_cfg_r   <= i_reg_wdata;
          `SVC_OFF_BAND_OVR:  band_ovr_r  <= i_reg_wdata;
          `SVC_OFF_AMPL_OVR:  ampl_ovr_r  <= i_reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // outputs, all registered
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata      <= 8'h00;
      o_cal_run        <= 1'b0;
      o_vco_band       <= 8'h00;
      o_vco_ampl       <= 8'h00;
      o_loop_bw        <= `SVC_BW_92;
      o_div4           <= 1'b0;
      o_gauss_en       <= 1'b0;
      o_tx_bit         <= 1'b0;
      o_receive_state  <= 1'b0;
      o_transmit_state <= 1'b0;
    end else begin
      o_cal_run  <= (state_nxt == ST_CAL);
      o_vco_band <= bypass ? band_ovr_r : band_res_r; // RULE_13
      o_vco_ampl <= bypass ? ampl_ovr_r : ampl_res_r;
      o_div4     <= i_vco_quad; // RULE_10
      // shaping filter is fixed at BT 0.5; only on/off is selectable
      o_gauss_en <= mod_cfg_r[`SVC_MOD_GAUSS_BIT] & ~mod_cfg_r[`SVC_MOD_OOK_BIT]; // RULE_11
      o_tx_bit   <= i_tx_bit;
      o_receive_state  <= (state_nxt == ST_ON) && !dir_tx_r; // RULE_14
      o_transmit_state <= (state_nxt == ST_ON) && dir_tx_r; // RULE_14
      if (cmd && (state_r == ST_IDLE || state_r == ST_ON)) begin
        if (i_go_receive_cmd && !i_go_transmit_cmd) begin
          o_loop_bw <= `SVC_BW_92; // RULE_09
        end else if (mod_cfg_r[`SVC_MOD_OOK_BIT]) begin
          o_loop_bw <= `SVC_BW_185; // RULE_08
        end else if (i_data_rate < `SVC_RATE_496) begin
          o_loop_bw <= `SVC_BW_130; // RULE_08
        end else if (i_data_rate < `SVC_RATE_1296) begin
          o_loop_bw <= `SVC_BW_174;
        end else if (i_data_rate < `SVC_RATE_1792) begin
          o_loop_bw <= `SVC_BW_226;
        end else if (i_data_rate < `SVC_RATE_2400) begin
          o_loop_bw <= `SVC_BW_305;
        end else begin
          o_loop_bw <= `SVC_BW_382;
        end
      end
      o_reg_rdata <= 8'h00;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `SVC_OFF_MOD_CFG:   o_reg_rdata <= mod_cfg_r;
          `SVC_OFF_MODE_CTL:  o_reg_rdata <= mode_ctl_r;
          `SVC_OFF_RX_SETTLE: o_reg_rdata <= rx_settle_r;
          `SVC_OFF_TX_SETTLE: o_reg_rdata <= tx_settle_r;
          `SVC_OFF_CAL_CTL:   o_reg_rdata <= cal_ctl_r;
          `SVC_OFF_CAL_DONE:  o_reg_rdata <= {6'h00, (state_r == ST_ON), vco_done_r}; // RULE_03
          `SVC_OFF_OVR_EN:    o_reg_rdata <= ovr_en_r;
          `SVC_OFF_CAL_CFG:   o_reg_rdata <= cal_cfg_r;
          `SVC_OFF_BAND_OVR:  o_reg_rdata <= band_ovr_r;
          `SVC_OFF_AMPL_OVR:  o_reg_rdata <= ampl_ovr_r;
          `SVC_OFF_BAND_RES:  o_reg_rdata <= band_res_r;
          `SVC_OFF_AMPL_RES:  o_reg_rdata <= ampl_res_r;
          default:            o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule // svc_synth_seq

// [test/svc_seq_checker.sv]
// Purpose: port checker for svc_synth_seq
// Assumes: one clock domain, async active-low reset
// Notes:   cal length counted in helper logic, no tool can see a stuck counter otherwise
`timescale 1ns/1ps
module svc_seq_checker (
  input wire       i_clk,
  input wire       i_arst_n,
  input wire       i_go_receive_cmd,
  input wire       i_go_transmit_cmd,
  input wire       i_reg_rd,
  input wire [9:0] i_reg_addr,
  input wire       i_vco_quad,
  input wire [7:0] o_reg_rdata,
  input wire       o_cal_run,
  input wire [2:0] o_loop_bw,
  input wire       o_div4,
  input wire       o_receive_state,
  input wire       o_transmit_state
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  reg  [15:0] cal_cnt_r;
  wire        st_any = o_receive_state | o_transmit_state;
  always @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n) cal_cnt_r <= 16'h0000;
    else cal_cnt_r <= o_cal_run ? cal_cnt_r + 16'h0001 : 16'h0000;
  sequence s_cal_end;
    $fell(o_cal_run);
  endsequence
  sequence s_cmd_in_state;
    (i_go_receive_cmd | i_go_transmit_cmd) && st_any;
  endsequence
  chk_cal_length:
    assert property (s_cal_end |-> cal_cnt_r == 16'h0DDE) else $error("calibration length wrong");
  chk_settle_after_cal:
    assert property (s_cal_end |-> !st_any [*8]) else $error("state before settling");
  chk_no_state_cal:
    assert property (o_cal_run |-> !st_any) else $error("state during calibration");
  chk_cmd_drops_state:
    assert property (s_cmd_in_state |=> ##[0:1] !st_any) else $error("state kept after command");
  chk_rx_narrow_bw:
    assert property ($rose(o_receive_state) |-> o_loop_bw == 3'h0) else $error("rx bandwidth wrong");
  chk_tx_bw_code:
    assert property (o_transmit_state |-> o_loop_bw inside {[3'h1:3'h6]}) else $error("tx bandwidth wrong");
  chk_divider_follows:
    assert property (1'b1 |=> o_div4 == $past(i_vco_quad)) else $error("divider wrong");
  chk_done_clear_cal:
    assert property (i_reg_rd && i_reg_addr == 10'h339 && o_cal_run && $past(o_cal_run) |=> !o_reg_rdata[0])
      else $error("done set during calibration");
  chk_rdata_idle_zero:
    assert property (!i_reg_rd |=> o_reg_rdata == 8'h00) else $error("read data not zero");
endmodule // svc_seq_checker
bind svc_synth_seq svc_seq_checker i_svc_seq_checker (.i_clk, .i_arst_n, .i_go_receive_cmd, .i_go_transmit_cmd,
  .i_reg_rd, .i_reg_addr, .i_vco_quad, .o_reg_rdata, .o_cal_run, .o_loop_bw, .o_div4, .o_receive_state,
  .o_transmit_state);

// [test/svc_cal_engine_model.sv]
// Purpose: behavioural analog vco calibration engine
// Assumes: results are only valid while calibration runs, plus one cycle
// Notes:   outside that window outputs churn so a late capture shows up
`timescale 1ns/1ps
module svc_cal_engine_model #(
  parameter [7:0] BAND = 8'h5A,
  parameter [7:0] AMPL = 8'h3C
) (
  input  wire       i_clk,
  input  wire       i_cal_run,
  output reg  [7:0] o_band,
  output reg  [7:0] o_ampl
);
  reg hold_r = 1'b0;
  reg tog_r  = 1'b0;
  always @(posedge i_clk) begin
    hold_r <= i_cal_run;
    tog_r  <= ~tog_r;
  end
  always @* begin
    o_band = (i_cal_run | hold_r) ? BAND : ~BAND ^ {8{tog_r}};
    o_ampl = (i_cal_run | hold_r) ? AMPL : ~AMPL ^ {8{tog_r}};
  end
endmodule // svc_cal_engine_model

// [test/tb_top.sv]
// Purpose: self-checking bench for svc_synth_seq
// Assumes: register port pulses, 25 MHz clock
// Notes:   latency windows allow a few cycles of pipeline slack
`timescale 1ns/1ps
`include "svc_defs.vh"
module tb_top;
  reg        i_clk = 1'b0;
  reg        i_arst_n = 1'b0;
  reg        i_go_receive_cmd = 1'b0;
  reg        i_go_transmit_cmd = 1'b0;
  reg        i_reg_wr = 1'b0;
  reg        i_reg_rd = 1'b0;
  reg [9:0]  i_reg_addr = 10'h000;
  reg [7:0]  i_reg_wdata = 8'h00;
  reg [11:0] i_data_rate = 12'h000;
  reg        i_vco_quad = 1'b0;
  reg        i_tx_bit = 1'b0;
  wire [7:0] i_cal_band, i_cal_ampl, o_reg_rdata, o_vco_band, o_vco_ampl;
  wire [2:0] o_loop_bw;
  wire       o_cal_run, o_div4, o_gauss_en, o_tx_bit, o_receive_state, o_transmit_state;
  int        err_total = 0, check_count = 0, cyc = 0, t0 = 0, t1 = 0;
  int        rates[5] = '{495, 496, 1296, 1792, 2400};
  reg [7:0]  d;
  svc_synth_seq i_svc_synth_seq (.i_clk, .i_arst_n, .i_go_receive_cmd, .i_go_transmit_cmd, .i_reg_wr, .i_reg_rd,
    .i_reg_addr, .i_reg_wdata, .i_data_rate, .i_vco_quad, .i_cal_band, .i_cal_ampl, .i_tx_bit, .o_reg_rdata,
    .o_cal_run, .o_vco_band, .o_vco_ampl, .o_loop_bw, .o_div4, .o_gauss_en, .o_tx_bit, .o_receive_state,
    .o_transmit_state);
  svc_cal_engine_model i_svc_cal_engine_model (.i_clk, .i_cal_run(o_cal_run), .o_band(i_cal_band),
    .o_ampl(i_cal_ampl));
  always #20 i_clk = ~i_clk;
  task give_verdict;
    $display("mismatches %0d comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 60000) begin
      err_total = err_total + 1;
      give_verdict;
    end
  end
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [9:0] a, input [7:0] v);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task rd(input [9:0] a);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
  endtask
  task start(input tx);
    @(posedge i_clk);
    t0 = cyc;
    i_go_transmit_cmd <= tx;
    i_go_receive_cmd <= !tx;
    @(posedge i_clk);
    i_go_transmit_cmd <= 1'b0;
    i_go_receive_cmd <= 1'b0;
  endtask
  // the state output is level, so wait at negedges where it has settled
  task waitst(input tx, input int lo);
    repeat (3) @(negedge i_clk);
    while (!(tx ? o_transmit_state : o_receive_state)) @(negedge i_clk);
    check("latency", {7'h00, (cyc - t0 >= lo) && (cyc - t0 <= lo + 10)}, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(`SVC_OFF_CAL_CTL);
    check("cal ctl reset", d, `SVC_RST_CALCTL);
    rd(`SVC_OFF_MOD_CFG);
    check("mod cfg reset", d, `SVC_RST_BYTE);
    wr(`SVC_OFF_CAL_DONE, 8'hFF);
    rd(`SVC_OFF_CAL_DONE);
    check("done read only", d, 8'h00);
    rd(10'h2AA);
    check("unmapped", d, 8'h00);
    wr(`SVC_OFF_MOD_CFG, 8'h10);
    i_data_rate <= 12'd300;
    i_vco_quad <= 1'b1;
    i_tx_bit <= 1'b1;
    start(1'b1);
    rd(`SVC_OFF_CAL_DONE);
    check("done busy", d & 8'h01, 8'h00);
    t1 = t0;
    start(1'b0);
    t0 = t1;
    waitst(1'b1, `SVC_CAL_CYC + `SVC_SETTLE_CYC);
    check("rx ignored", o_receive_state, 8'h00);
    rd(`SVC_OFF_CAL_DONE);
    check("done set", d, 8'h03);
    rd(`SVC_OFF_BAND_RES);
    check("band result", d, 8'h5A);
    rd(`SVC_OFF_AMPL_RES);
    check("ampl result", d, 8'h3C);
    check("tx bw low", o_loop_bw, `SVC_BW_130);
    check("div4", o_div4, 8'h01);
    check("gauss on", o_gauss_en, 8'h01);
    check("tx bit", o_tx_bit, 8'h01);
    wr(`SVC_OFF_MODE_CTL, 8'h08);
    wr(`SVC_OFF_RX_SETTLE, 8'h03);
    wr(`SVC_OFF_TX_SETTLE, 8'h00);
    i_vco_quad <= 1'b0;
    start(1'b0);
    waitst(1'b0, `SVC_CAL_CYC + 4 * `SVC_STEP_CYC);
    check("rx bw", o_loop_bw, `SVC_BW_92);
    check("div2", o_div4, 8'h00);
    // first band edge on both sides, the other edges from above only; shortest custom settle
    for (int k = 0; k < 5; k++) begin
      i_data_rate <= rates[k][11:0];
      start(1'b1);
      waitst(1'b1, `SVC_CAL_CYC + `SVC_STEP_CYC);
      check("tx bw band", o_loop_bw, k[7:0] + 8'h01);
    end
    wr(`SVC_OFF_MOD_CFG, 8'h14);
    start(1'b1);
    waitst(1'b1, `SVC_CAL_CYC + `SVC_STEP_CYC);
    check("ook bw", o_loop_bw, `SVC_BW_185);
    check("gauss off", o_gauss_en, 8'h00);
    wr(`SVC_OFF_MODE_CTL, 8'h00);
    wr(`SVC_OFF_OVR_EN, `SVC_OVR_BYPASS);
    wr(`SVC_OFF_CAL_CFG, `SVC_CFG_BYPASS);
    wr(`SVC_OFF_BAND_OVR, 8'hA5);
    wr(`SVC_OFF_AMPL_OVR, 8'hC3);
    wr(`SVC_OFF_CAL_CTL, 8'h00);
    wr(`SVC_OFF_CAL_CTL, 8'h01);
    start(1'b0);
    waitst(1'b0, `SVC_SETTLE_CYC);
    check("band override", o_vco_band, 8'hA5);
    check("ampl override", o_vco_ampl, 8'hC3);
    give_verdict;
  end
endmodule // tb_top
